/* File: src/timer8_compare_ctc.sv */
// timer8_compare_ctc: 8-bit up counter with two compare channels, normal
// and clear-on-compare modes, reached over APB; assumes a CPU core that
// acknowledges each interrupt it services with a one-cycle pulse.
// Operation
// - The count is compared with both compare values at all times.
// - A match sets its compare flag at the next timer clock tick.
// - A set and enabled flag requests an interrupt; service clears it.
// - Writing one to a flag bit clears it; writing zero keeps it.
// - A count write blocks all matches up to and including the next timer tick.
// - Normal mode counts up only and wraps from 0xFF to 0x00.
// - Normal mode sets overflow as the count becomes zero.
// - Clear-on-compare mode clears the count on a match with A.
// - Compare writes act at once; a top below the count wraps first.
// - Clear-on-compare mode also sets overflow on 0xFF to 0x00.
// - The upper four control bits always read as zero.
// - Clock select codes 0 to 5 pick stop, undivided or a tap.
// - Codes 6 and 7 count falling or rising edges of the pin.
// - The pin is counted even when it is driven as an output.
// - Software reads and writes the count with or without a clock.
// - A count write wins over a coincident count or clear.
`timescale 1ns/1ps
`default_nettype none
module timer8_compare_ctc
  import timer8_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  // external count pin, sampled even while driven as an output
  input  wire logic              external_count_pin_i,
  // interrupt requests and service acknowledges, bit order of the flags
  output logic [2:0]             irq_o,
  input  wire logic [2:0]        irq_ack_i
);

  timer_control_t   control;
  logic [7:0]       count_value;
  logic [7:0]       compare_value_a;
  logic [7:0]       compare_value_b;
  timer_flags_t     flags;
  logic [2:0]       enables;
  logic [PRE_W-1:0] prescale;
  logic             block;
  logic             ext_rise;
  logic             ext_fall;
  logic             timer_clock_enable;
  logic             match_a;
  logic             match_b;
  logic             set_a;
  logic             set_b;
  logic             set_ovf;
  logic             setup;
  logic             wr_take;
  logic             wr_ctrl;
  logic             wr_count;
  logic             wr_cmp_a;
  logic             wr_cmp_b;
  logic             wr_flags;
  logic             wr_enable;
  logic             mapped;
  logic [7:0]       read_mux;
  logic [2:0]       flag_clear;
  timer_flags_t     next_flags;

  // zero wait states: read data is captured in the setup cycle
  assign pready_o = 1'b1;
  assign setup    = psel_i && !penable_i;
  assign wr_take  = psel_i && penable_i && pwrite_i && pstrb_i[0];

  always_comb begin
    mapped    = 1'b1;
    read_mux  = 8'h00;
    wr_ctrl   = 1'b0;
    wr_count  = 1'b0;
    wr_cmp_a  = 1'b0;
    wr_cmp_b  = 1'b0;
    wr_flags  = 1'b0;
    wr_enable = 1'b0;
    if (paddr_i == ADDR_CONTROL_A) begin
      read_mux = {4'h0, control.clear_on_compare_sel,
                  control.clock_select};
      wr_ctrl  = wr_take;
    end else if (paddr_i == ADDR_COUNT) begin
      read_mux = count_value;
      wr_count = wr_take;
    end else if (paddr_i == ADDR_COMPARE_A) begin
      read_mux = compare_value_a;
      wr_cmp_a = wr_take;
    end else if (paddr_i == ADDR_COMPARE_B) begin
      read_mux = compare_value_b;
      wr_cmp_b = wr_take;
    end else if (paddr_i == ADDR_FLAGS) begin
      read_mux = {5'h00, flags};
      wr_flags = wr_take;
    end else if (paddr_i == ADDR_ENABLE) begin
      read_mux  = {5'h00, enables};
      wr_enable = wr_take;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= {24'h00_0000, read_mux};
      pslverr_o <= !mapped;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      control <= timer_control_t'(RST_CONTROL_A);
    end else if (wr_ctrl) begin
      control.reserved             <= 4'h0;
      control.clear_on_compare_sel <= pwdata_i[3];
      control.clock_select         <= clock_select_t'(pwdata_i[2:0]);
    end
  end

  // compare values take effect at once, no shadow copy
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      compare_value_a <= RST_COMPARE;
      compare_value_b <= RST_COMPARE;
    end else begin
      if (wr_cmp_a) begin
        compare_value_a <= pwdata_i[7:0];
      end
      if (wr_cmp_b) begin
        compare_value_b <= pwdata_i[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      enables <= RST_ENABLE;
    end else if (wr_enable) begin
      enables <= pwdata_i[2:0];
    end
  end

  // free-running prescaler shared by all taps
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prescale <= '0;
    end else begin
      prescale <= PRE_W'(prescale + 1'b1);
    end
  end

  // pin is never qualified by a direction bit
  timer8_edge_sync u_edge_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .pin_i     (external_count_pin_i),
    .rise_o    (ext_rise),
    .fall_o    (ext_fall)
  );

  always_comb begin
    case (control.clock_select)
      CS_STOP:     timer_clock_enable = 1'b0;
      CS_DIV1:     timer_clock_enable = 1'b1;
      CS_DIV8:     timer_clock_enable =
                     (prescale & PRE_MASK_8) == PRE_MASK_8;
      CS_DIV64:    timer_clock_enable =
                     (prescale & PRE_MASK_64) == PRE_MASK_64;
      CS_DIV256:   timer_clock_enable =
                     (prescale & PRE_MASK_256) == PRE_MASK_256;
      CS_DIV1024:  timer_clock_enable =
                     (prescale & PRE_MASK_1024) == PRE_MASK_1024;
      CS_EXT_FALL: timer_clock_enable = ext_fall;
      CS_EXT_RISE: timer_clock_enable = ext_rise;
      default:     timer_clock_enable = 1'b0;
    endcase
  end

  assign match_a = (count_value == compare_value_a);
  assign match_b = (count_value == compare_value_b);

  // block lingers through a stopped timer until a tick consumes it
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      block <= 1'b0;
    end else if (wr_count) begin
      block <= 1'b1;
    end else if (timer_clock_enable) begin
      block <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_value <= RST_COUNT;
    end else if (wr_count) begin
      count_value <= pwdata_i[7:0];
    end else if (timer_clock_enable) begin
      if (control.clear_on_compare_sel && match_a && !block) begin
        count_value <= COUNT_BOTTOM;
      end else begin
        count_value <= 8'(count_value + 8'h01);
      end
    end
  end

  assign set_a   = timer_clock_enable && match_a && !block;
  assign set_b   = timer_clock_enable && match_b && !block;
  assign set_ovf = timer_clock_enable && !wr_count &&
                   (count_value == COUNT_MAX);

  assign flag_clear = ({3{wr_flags}} & pwdata_i[2:0]) | irq_ack_i;

  // a set in the cycle of a clear wins
  always_comb begin
    next_flags = flags & timer_flags_t'(~flag_clear);
    if (set_a) begin
      next_flags.compare_flag_a = 1'b1;
    end
    if (set_b) begin
      next_flags.compare_flag_b = 1'b1;
    end
    if (set_ovf) begin
      next_flags.overflow_flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      flags <= timer_flags_t'(RST_FLAGS);
    end else begin
      flags <= next_flags;
    end
  end

  assign irq_o = flags & enables;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  AST_FLAG_A_ON_TICK: assert property (
    timer_clock_enable && match_a && !block |=> flags.compare_flag_a)
    else $error("compare flag a missed a tick match");

  AST_FLAG_B_CAUSE: assert property (
    $rose(flags.compare_flag_b) |->
      $past(timer_clock_enable) && $past(match_b))
    else $error("compare flag b rose without a tick match");

  AST_BLOCKED_TICK: assert property (
    wr_count ##1 (!wr_count && timer_clock_enable) |=>
      !$rose(flags.compare_flag_a) && !$rose(flags.compare_flag_b))
    else $error("match not blocked after count write");

  AST_NORMAL_WRAP: assert property (
    timer_clock_enable && !wr_count && !control.clear_on_compare_sel &&
    count_value == COUNT_MAX |=>
      count_value == COUNT_BOTTOM && flags.overflow_flag)
    else $error("normal mode wrap or overflow wrong");

  AST_OVF_CAUSE: assert property (
    $rose(flags.overflow_flag) |-> count_value == COUNT_BOTTOM)
    else $error("overflow flag set away from zero");

  AST_CTC_CLEAR: assert property (
    timer_clock_enable && !wr_count && control.clear_on_compare_sel &&
    match_a && !block |=> count_value == COUNT_BOTTOM)
    else $error("count not cleared at compare a");

  AST_CPU_WINS: assert property (
    wr_count |=> count_value == $past(pwdata_i[7:0]))
    else $error("count write lost");

  AST_STOPPED: assert property (
    control.clock_select == CS_STOP && !wr_count |=> $stable(count_value))
    else $error("stopped timer moved");

  AST_W1C: assert property (
    wr_flags && pwdata_i[BIT_COMPARE_A] && !set_a |=>
      !flags.compare_flag_a)
    else $error("write one did not clear compare flag a");

  AST_ACK_CLEAR: assert property (
    irq_ack_i[BIT_OVERFLOW] && !set_ovf |=> !irq_o[BIT_OVERFLOW])
    else $error("serviced overflow request still pending");

  AST_RESERVED_ZERO: assert property (
    setup && paddr_i == ADDR_CONTROL_A |=> prdata_o[31:4] == 28'h0000000)
    else $error("reserved control bits read nonzero");

  COV_CTC_TOP: cover property (
    control.clear_on_compare_sel && set_a ##1 count_value == COUNT_BOTTOM);
  COV_OVERFLOW: cover property (set_ovf);
  COV_BLOCKED: cover property (block && timer_clock_enable && match_a);
  COV_EXT_COUNT: cover property (
    control.clock_select == CS_EXT_RISE && timer_clock_enable);

endmodule // timer8_compare_ctc
`default_nettype wire

/* File: src/timer8_edge_sync.sv */
// timer8_edge_sync: brings the external count pin into the clock domain
// and gives one-cycle pulses on its settled rising and falling edges.
// assumes the pin is asynchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module timer8_edge_sync (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // pin
  input  wire logic pin_i,
  // edge pulses
  output logic      rise_o,
  output logic      fall_o
);

  logic [2:0] sync;
  logic [2:0] filled;
  logic       level;
  logic       primed;

  // zeros left by reset are not pin samples: the chain counts as settled
  // only once three real samples have been shifted in
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync   <= 3'h0;
      filled <= 3'h0;
    end else begin
      sync   <= {sync[1:0], pin_i};
      filled <= {filled[1:0], 1'b1};
    end
  end

  // first settled level after reset is taken without a pulse, so a pin
  // that idles high does not fake an edge
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      level  <= 1'b0;
      primed <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (filled[2] && (sync[1] == sync[2])) begin
        primed <= 1'b1;
        level  <= sync[2];
        if (primed && (sync[2] != level)) begin
          rise_o <= sync[2];
          fall_o <= ~sync[2];
        end
      end
    end
  end

endmodule // timer8_edge_sync
`default_nettype wire

/* File: src/timer8_pkg.sv */
// timer8_pkg: register map, field layouts, reset values and prescaler taps
// for the 8-bit compare timer; assumes 32-bit APB, one register per word.
package timer8_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL_A = 8'h25;
  localparam logic [7:0] IDX_COUNT     = 8'h26;
  localparam logic [7:0] IDX_COMPARE_A = 8'h27;
  localparam logic [7:0] IDX_COMPARE_B = 8'h28;
  localparam logic [7:0] IDX_FLAGS     = 8'h35;
  localparam logic [7:0] IDX_ENABLE    = 8'h6E;

  localparam int unsigned APB_AW = 12;

  localparam logic [11:0] ADDR_CONTROL_A = {2'b00, IDX_CONTROL_A, 2'b00};
  localparam logic [11:0] ADDR_COUNT     = {2'b00, IDX_COUNT, 2'b00};
  localparam logic [11:0] ADDR_COMPARE_A = {2'b00, IDX_COMPARE_A, 2'b00};
  localparam logic [11:0] ADDR_COMPARE_B = {2'b00, IDX_COMPARE_B, 2'b00};
  localparam logic [11:0] ADDR_FLAGS     = {2'b00, IDX_FLAGS, 2'b00};
  localparam logic [11:0] ADDR_ENABLE    = {2'b00, IDX_ENABLE, 2'b00};

  // values after reset
  localparam logic [7:0] RST_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_COUNT     = 8'h00;
  localparam logic [7:0] RST_COMPARE   = 8'h00;
  localparam logic [2:0] RST_FLAGS     = 3'h0;
  localparam logic [2:0] RST_ENABLE    = 3'h0;

  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // flag and enable bit positions
  localparam int unsigned BIT_OVERFLOW  = 0;
  localparam int unsigned BIT_COMPARE_A = 1;
  localparam int unsigned BIT_COMPARE_B = 2;

  // prescaler taps
  localparam int unsigned PRE_W    = 10;
  localparam int unsigned DIV_8    = 8;
  localparam int unsigned DIV_64   = 64;
  localparam int unsigned DIV_256  = 256;
  localparam int unsigned DIV_1024 = 1024;
  localparam logic [PRE_W-1:0] PRE_MASK_8    = PRE_W'(DIV_8 - 1);
  localparam logic [PRE_W-1:0] PRE_MASK_64   = PRE_W'(DIV_64 - 1);
  localparam logic [PRE_W-1:0] PRE_MASK_256  = PRE_W'(DIV_256 - 1);
  localparam logic [PRE_W-1:0] PRE_MASK_1024 = PRE_W'(DIV_1024 - 1);

  typedef enum logic [2:0] {
    CS_STOP     = 3'b000,
    CS_DIV1     = 3'b001,
    CS_DIV8     = 3'b010,
    CS_DIV64    = 3'b011,
    CS_DIV256   = 3'b100,
    CS_DIV1024  = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } clock_select_t;

  typedef struct packed {
    logic [3:0]    reserved;
    logic          clear_on_compare_sel;
    clock_select_t clock_select;
  } timer_control_t;

  typedef struct packed {
    logic compare_flag_b;
    logic compare_flag_a;
    logic overflow_flag;
  } timer_flags_t;

endpackage

/* File: verification/timer8_compare_ctc_tb.sv */
// timer8_compare_ctc_tb: self-checking bench, random with corner cases;
// assumes the cpu model as apb master and the bench driving the pin.
`timescale 1ns/1ps
`default_nettype none
module timer8_compare_ctc_tb
  import timer8_pkg::*;
();
  logic              ref_clk_i, reset_i, pin, svc_en, timeout, err;
  logic              psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, seed;
  logic [3:0]        pstrb;
  logic [2:0]        irq, ack;
  logic [7:0]        v;
  int                err_total, checks_done, n;
  logic [APB_AW-1:0] regs [6] = '{ADDR_CONTROL_A, ADDR_COUNT,
    ADDR_COMPARE_A, ADDR_COMPARE_B, ADDR_FLAGS, ADDR_ENABLE};

  timer8_compare_ctc uut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr),
    .external_count_pin_i(pin), .irq_o(irq), .irq_ack_i(ack));

  timer8_cpu_model cpu (
    .ref_clk_i(ref_clk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
    .pstrb_o(pstrb), .pready_i(pready), .prdata_i(prdata),
    .pslverr_i(pslverr), .irq_i(irq), .service_en_i(svc_en),
    .irq_ack_o(ack), .timeout_o(timeout));

  always #50 ref_clk_i = ~ref_clk_i;

  task automatic finish_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    if (timeout === 1'b1) begin
      err_total++;
      finish_test();
    end
  end

  task automatic check32(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // timer clock edges in a window of 2*(k+1) cycles, phase-independent
  function automatic int exp_ticks(input int cs, input int k);
    int unsigned d;
    d = (cs == 1) ? 1 : (cs == 2) ? DIV_8 : (cs == 3) ? DIV_64 :
        (cs == 4) ? DIV_256 : DIV_1024;
    return (cs == 0) ? 0 : 2 * (k + 1) / d;
  endfunction

  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d,
                    input logic keep = 1'b0);
    cpu.xfer(1'b1, a, d, keep, rd, err);
  endtask

  task automatic rc(input string what, input logic [APB_AW-1:0] a,
                    input logic [31:0] exp);
    cpu.xfer(1'b0, a, 32'h0, 1'b0, rd, err);
    check32(what, exp, rd);
  endtask

  // run the timer for a window made of back-to-back transfers, then stop
  task automatic run(input logic [7:0] ctl, input int k);
    wr(ADDR_CONTROL_A, {24'h0, ctl}, 1'b1);
    repeat (k) cpu.xfer(1'b0, ADDR_COUNT, 32'h0, 1'b1, rd, err);
    wr(ADDR_CONTROL_A, {24'h0, ctl & 8'h08});
  endtask

  initial begin
    ref_clk_i   = 1'b0;
    reset_i     = 1'b1;
    pin         = 1'b0;
    svc_en      = 1'b0;
    seed        = 32'h0C019817;
    err_total   = 0;
    checks_done = 0;
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    foreach (regs[i]) rc("reset value", regs[i], 32'h0);
    cpu.xfer(1'b0, 12'h000, 32'h0, 1'b0, rd, err);
    check32("unmapped error", 32'h1, {31'h0, err});
    wr(ADDR_CONTROL_A, 32'hFF);
    rc("control", ADDR_CONTROL_A, 32'h0F);
    wr(ADDR_CONTROL_A, 32'h00);
    v = 8'(xs());
    wr(ADDR_COUNT, {24'h0, v});
    rc("count", ADDR_COUNT, {24'h0, v});
    wr(ADDR_COMPARE_B, 32'hFF);
    wr(ADDR_COUNT, 32'hFE);
    run(8'h01, 0);
    rc("count wrap", ADDR_COUNT, 32'h00);
    rc("flags wrap", ADDR_FLAGS, 32'h5);
    wr(ADDR_ENABLE, 32'h1);
    @(negedge ref_clk_i);
    check32("irq masked", 32'h1, {29'h0, irq});
    svc_en <= 1'b1;
    n = 0;
    while (irq !== 3'h0 && n < 20) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 20) begin
      err_total++;
      finish_test();
    end
    svc_en <= 1'b0;
    rc("flags serviced", ADDR_FLAGS, 32'h4);
    wr(ADDR_FLAGS, 32'h0);
    rc("flags kept", ADDR_FLAGS, 32'h4);
    wr(ADDR_FLAGS, 32'h4);
    rc("flags cleared", ADDR_FLAGS, 32'h0);
    wr(ADDR_COMPARE_A, 32'h40);
    wr(ADDR_COUNT, 32'h40);
    run(8'h01, 0);
    rc("flags blocked", ADDR_FLAGS, 32'h0);
    wr(ADDR_COUNT, 32'h3F);
    run(8'h01, 0);
    rc("flags match", ADDR_FLAGS, 32'h2);
    wr(ADDR_FLAGS, 32'h7);
    wr(ADDR_COMPARE_A, 32'h03);
    wr(ADDR_COUNT, 32'h00);
    run(8'h09, 2);
    rc("top count", ADDR_COUNT, 32'h02);
    rc("top flags", ADDR_FLAGS, 32'h2);
    wr(ADDR_FLAGS, 32'h7);
    wr(ADDR_COMPARE_B, 32'h80);
    wr(ADDR_COUNT, 32'hFD);
    wr(ADDR_COMPARE_A, 32'h05);
    run(8'h09, 1);
    rc("late top count", ADDR_COUNT, 32'h01);
    rc("late top flags", ADDR_FLAGS, 32'h1);
    wr(ADDR_CONTROL_A, 32'h01, 1'b1);
    wr(ADDR_COUNT, 32'h80, 1'b1);
    wr(ADDR_CONTROL_A, 32'h00);
    rc("count write wins", ADDR_COUNT, 32'h82);
    for (int cs = 0; cs < 6; cs++) begin
      n = (cs == 0) ? 3 : 2 * exp_ticks(cs, 0) - 1;
      n = (cs < 2) ? n : ((cs == 2) ? DIV_8 : (cs == 3) ? DIV_64 :
          (cs == 4) ? DIV_256 : DIV_1024) - 1;
      v = 8'(xs());
      wr(ADDR_COUNT, {24'h0, v});
      run(8'(cs), n);
      rc("prescaled count", ADDR_COUNT,
         {24'h0, v + 8'(exp_ticks(cs, n))});
    end
    for (int m = 6; m < 8; m++) begin
      n = 1 + int'(xs() % 8);
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_CONTROL_A, m);
      // software toggles the pin as an output would: n rises, n-1 falls
      for (int p = 0; p < 2 * n - 1; p++) begin
        pin <= ~pin;
        repeat (4) @(posedge ref_clk_i);
      end
      repeat (8) @(posedge ref_clk_i);
      wr(ADDR_CONTROL_A, 32'h00);
      pin <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      rc("pin count", ADDR_COUNT,
         32'((m == 7) ? n : n - 1));
    end
    finish_test();
  end
endmodule // timer8_compare_ctc_tb
`default_nettype wire

/* File: verification/timer8_cpu_model.sv */
// timer8_cpu_model: cpu core side of the timer, an apb master driven by
// tasks plus an interrupt service loop; assumes one rising-edge clock.
`timescale 1ns/1ps
`default_nettype none
module timer8_cpu_model
  import timer8_pkg::*;
(
  // clock
  input  wire logic              ref_clk_i,
  // apb master
  output logic                   psel_o,
  output logic                   penable_o,
  output logic                   pwrite_o,
  output logic [APB_AW-1:0]      paddr_o,
  output logic [31:0]            pwdata_o,
  output logic [3:0]             pstrb_o,
  input  wire logic              pready_i,
  input  wire logic [31:0]       prdata_i,
  input  wire logic              pslverr_i,
  // interrupts and status
  input  wire logic [2:0]        irq_i,
  input  wire logic              service_en_i,
  output logic [2:0]             irq_ack_o,
  output logic                   timeout_o
);
  logic held;

  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = '0;
    pwdata_o  = '0;
    pstrb_o   = 4'hF;
    irq_ack_o = 3'h0;
    timeout_o = 1'b0;
    held      = 1'b0;
  end

  // called just after a rising edge; keep runs the next setup back to back
  task automatic xfer(input logic wr, input logic [APB_AW-1:0] addr,
                      input logic [31:0] data, input logic keep,
                      output logic [31:0] rdata, output logic err);
    int n;
    if (!held) @(posedge ref_clk_i);
    psel_o    <= 1'b1;
    pwrite_o  <= wr;
    paddr_o   <= addr;
    pwdata_o  <= data;
    @(posedge ref_clk_i);
    penable_o <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 16);
    if (pready_i !== 1'b1) timeout_o <= 1'b1;
    rdata = prdata_i;
    err   = pslverr_i;
    penable_o <= 1'b0;
    // released lines show the inverse so a stale value is never trusted
    if (!keep) begin
      psel_o   <= 1'b0;
      paddr_o  <= ~addr;
      pwdata_o <= ~data;
    end
    held = keep;
  endtask

  // one acknowledge pulse per pending request, like a vector being taken
  always @(posedge ref_clk_i) begin
    irq_ack_o <= irq_i & {3{service_en_i}} & ~irq_ack_o;
  end
endmodule // timer8_cpu_model
`default_nettype wire
